// ==== common/lgc_consts.svh ====
`ifndef LGC_CONSTS_SVH
`define LGC_CONSTS_SVH
// Register offsets
`define LGC_A_IN_HI      8'h00
`define LGC_A_IN_LO      8'h01
`define LGC_A_OUT_HI     8'h02
`define LGC_A_OUT_LO     8'h03
`define LGC_A_DIR_HI     8'h04
`define LGC_A_DIR_LO     8'h05
`define LGC_A_BLK_HI     8'h06
`define LGC_A_BLK_LO     8'h07
`define LGC_A_GCTL       8'h11
`define LGC_A_KIND_HI    8'h12
`define LGC_A_KIND_LO    8'h13
`define LGC_A_BREATH     8'h14
`define LGC_A_RAMP       8'h15
`define LGC_A_HOLD       8'h16
`define LGC_A_BRIGHT0    8'h20
`define LGC_A_BRIGHT5    8'h25
`define LGC_A_SWRST      8'h7f
`define LGC_SWRST_CODE   8'h00
// Channel groups: high pair is channels 5:4, low quad is 3:0
`define LGC_HI           5:4
`define LGC_LO           3:0
`define LGC_HI_FLD       1:0
`define LGC_LO_FLD       3:0
`define LGC_CH6_FLD      5:0
`define LGC_OD_FIRST     4
// Global control fields
`define LGC_GC_GO        7
`define LGC_GC_DRIVE     4
`define LGC_GC_RANGE     1:0
// Timer fields
`define LGC_T_SLOW       5:3
`define LGC_T_FAST       2:0
// Reset values
`define LGC_RST_KIND     6'h3f
`define LGC_RST_ZERO6    6'h00
`define LGC_RST_BYTE     8'h00
`define LGC_LVL_MAX      6'h3f
`define LGC_LVL_MIN      6'h00
// Timing: one base step is one 64th of the 315 ms unit
`define LGC_CLK_MHZ      100
`define LGC_BASE_TIME_US 315000
`define LGC_FADE_STEPS   64
`define LGC_STEP_CYCLES  ((`LGC_BASE_TIME_US * `LGC_CLK_MHZ) / `LGC_FADE_STEPS)
`define LGC_HOLD_SHIFT   6'h00
`endif

// ==== common/lgc_pkg.sv ====
// Purpose: types shared by the channel register bank
// Assumes: six channels
// Notes:   widths only; numbers live in lgc_consts.svh
package lgc_pkg;
  typedef enum logic [2:0] {
    BL_IDLE = 3'b000,
    BL_UP   = 3'b001,
    BL_ON   = 3'b010,
    BL_DOWN = 3'b011,
    BL_OFF  = 3'b100
  } lgc_phase_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lgc_req_t;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } lgc_rsp_t;

  typedef struct packed {
    logic [5:0]      sink_en;
    logic [1:0]      current_range_select;
    logic [5:0][7:0] brightness_code;
  } lgc_led_t;

  typedef struct packed {
    logic [5:0]      out_lvl;
    logic [5:0]      dir;
    logic [5:0]      irq_blk;
    logic [5:0]      kind;
    logic [5:0]      breath_en;
    logic            go;
    logic            drive_style_select;
    logic [1:0]      current_range_select;
    logic [5:0]      ramp_timer;
    logic [5:0]      hold_timer;
    logic [5:0][7:0] bright;
  } lgc_cfg_t;

  typedef struct packed {
    lgc_phase_t      phase;
    logic [5:0]      blink_lvl;
    logic [10:0]     hold_cnt;
    logic [5:0][5:0] fade_lvl;
    logic [19:0]     pre_cnt;
    logic [4:0]      up_cnt;
    logic [4:0]      dn_cnt;
  } lgc_eng_t;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] in_lvl;
    logic [5:0] pend;
    logic [1:0] st1;
    logic [1:0] st2;
    logic [1:0] st3;
    logic [1:0] strap_cnt;
    logic       strap_done;
  } lgc_io_t;

  typedef struct packed {
    lgc_cfg_t   cfg;
    lgc_eng_t   eng;
    lgc_io_t    io;
    lgc_rsp_t   rsp;
    lgc_led_t   led;
    logic [5:0] pin_o;
    logic [5:0] pin_oe;
  } lgc_state_t;
endpackage

// ==== verilog/lgc_regs.sv ====
// Purpose: register bank and per-channel LED / general-purpose pin control
// Assumes: byte register port from the serial slave engine, 100 MHz clock
// Notes:   pin and strap inputs are asynchronous and pass three flops
//
// Notes on behaviour
// - Brightness code maps linearly; zero is off, 255 full selected scale.
// - Writing one to the run bit starts periodic blink breathing.
// - Drive-style bit: channels 4,5 open-drain at zero, push-pull at one.
// - Two-bit range picks full-scale current for all codes; resets 00.
// - Mode bit zero is LED driver, one is general pin; resets one.
// - Per-channel breathing enable bits, one turns breathing on; reset zero.
// - Ramp timer holds fade-down in bits 5:3, fade-up in 2:0.
// - Time codes 1..5 double from 315 ms; 0, 6, 7 mean zero.
// - Hold timer holds dark time in 5:3, lit time in 2:0.
// - Input registers return the sampled pin level per channel.
// - General pin output bit drives the pin low or high.
// - In latched fade, output bit rise fades up, fall fades down.
// - Output-level reset value comes from the two address straps.
// - General pin direction bit: zero output, one input; resets zero.
// - With breathing on, direction zero is latched fade, one is blink.
// - Mask bit zero allows an input interrupt, one blocks it.
// - Writing 00 to the reset register resets; reading gives identity.
// - Brightness writes are ignored while the channel is in latched fade.
`include "lgc_consts.svh"

module lgc_regs
  import lgc_pkg::*;
#(
  parameter int unsigned P_STEP_CYCLES = `LGC_STEP_CYCLES,
  // Arbitrary identity value
  parameter logic [7:0]  P_IDENT       = 8'h5a
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  // Register port
  input  wire lgc_req_t   i_req,
  output lgc_rsp_t        o_rsp,
  // Channel pins
  input  wire logic [5:0] i_pin_in,
  output logic [5:0]      o_pin_out,
  output logic [5:0]      o_pin_oe,
  // Address straps
  input  wire logic       i_address_strap_low,
  input  wire logic       i_address_strap_high,
  // Current sinks
  output lgc_led_t        o_led,
  // Interrupt
  output logic            o_irq_out_low_n
);

  localparam logic [19:0] STEP_LAST = 20'(P_STEP_CYCLES - 1);

  function automatic lgc_cfg_t cfg_reset();
    lgc_cfg_t c;
    c                      = '0;
    c.out_lvl              = `LGC_RST_ZERO6;
    c.dir                  = `LGC_RST_ZERO6;
    c.irq_blk              = `LGC_RST_ZERO6;
    c.kind                 = `LGC_RST_KIND;
    c.breath_en            = `LGC_RST_ZERO6;
    c.ramp_timer           = `LGC_RST_ZERO6;
    c.hold_timer           = `LGC_RST_ZERO6;
    return c;
  endfunction

  localparam lgc_cfg_t   CFG_RST = cfg_reset();
  localparam lgc_state_t ST_RST  = '{cfg: CFG_RST, eng: '0, io: '0, rsp: '0,
                                    led: '0, pin_o: '0, pin_oe: '0};

  // Time code to multiple of the base unit, zero meaning instant
  function automatic logic [4:0] time_mult(input logic [2:0] code);
    case (code)
      3'h1:    return 5'h01;
      3'h2:    return 5'h02;
      3'h3:    return 5'h04;
      3'h4:    return 5'h08;
      3'h5:    return 5'h10;
      default: return 5'h00;
    endcase
  endfunction

  // Hold length in base steps
  function automatic logic [10:0] hold_len(input logic [2:0] code);
    return {time_mult(code), `LGC_HOLD_SHIFT};
  endfunction

  // 64-step level onto the 8-bit code scale, 63 lands on 255
  function automatic logic [7:0] expand(input logic [5:0] lvl);
    return {lvl, lvl[5:4]};
  endfunction

  function automatic logic [7:0] rd_hi(input logic [5:0] v);
    return {6'h00, v[`LGC_HI]};
  endfunction

  function automatic logic [7:0] rd_lo(input logic [5:0] v);
    return {4'h0, v[`LGC_LO]};
  endfunction

  lgc_state_t r;
  lgc_state_t n;
  logic [5:0] fade_m;
  logic [5:0] blink_m;
  logic [5:0] evt;
  logic [5:0] rd_clr;
  logic       base_tick;
  logic       up_tick;
  logic       dn_tick;
  logic       swrst;
  logic       strap_load;
  logic [4:0] m_up;
  logic [4:0] m_dn;
  logic [2:0] bch;

  always_comb begin
    n          = r;
    evt        = '0;
    rd_clr     = '0;
    swrst      = 1'b0;
    strap_load = 1'b0;
    bch        = 3'(i_req.addr - `LGC_A_BRIGHT0);

    fade_m  = ~r.cfg.kind & r.cfg.breath_en & ~r.cfg.dir;
    blink_m = ~r.cfg.kind & r.cfg.breath_en & r.cfg.dir;

    // pin sampling, level accepted once stages two and three agree
    n.io.s1 = i_pin_in;
    n.io.s2 = r.io.s1;
    n.io.s3 = r.io.s2;
    for (int c = 0; c < 6; c++) begin
      if (r.io.s2[c] == r.io.s3[c]) begin
        n.io.in_lvl[c] = r.io.s3[c];
        // change on an unmasked general input
        evt[c] = (r.io.s3[c] != r.io.in_lvl[c]) && r.cfg.kind[c] && r.cfg.dir[c]
                 && !r.cfg.irq_blk[c];
      end
    end

    // straps settle three edges after reset, then set output levels
    n.io.st1 = {i_address_strap_high, i_address_strap_low};
    n.io.st2 = r.io.st1;
    n.io.st3 = r.io.st2;
    if (!r.io.strap_done) begin
      if (r.io.strap_cnt != 2'h3) begin
        n.io.strap_cnt = r.io.strap_cnt + 2'h1;
      end else if (r.io.st2 == r.io.st3) begin
        strap_load      = 1'b1;
        n.io.strap_done = 1'b1;
        n.cfg.out_lvl   = {6{|r.io.st3}};
      end
    end

    // shared step prescaler and per-direction rate dividers
    m_up      = time_mult(r.cfg.ramp_timer[`LGC_T_FAST]);
    m_dn      = time_mult(r.cfg.ramp_timer[`LGC_T_SLOW]);
    base_tick = (r.eng.pre_cnt >= STEP_LAST);
    up_tick   = base_tick && (m_up != 5'h00) && (r.eng.up_cnt >= 5'(m_up - 5'h01));
    dn_tick   = base_tick && (m_dn != 5'h00) && (r.eng.dn_cnt >= 5'(m_dn - 5'h01));
    n.eng.pre_cnt = base_tick ? 20'h00000 : r.eng.pre_cnt + 20'h00001;
    if (base_tick) begin
      n.eng.up_cnt = up_tick ? 5'h00 : r.eng.up_cnt + 5'h01;
      n.eng.dn_cnt = dn_tick ? 5'h00 : r.eng.dn_cnt + 5'h01;
    end

    // blink engine shared by all blink channels
    if (!r.cfg.go) begin
      n.eng.phase     = BL_IDLE;
      n.eng.blink_lvl = `LGC_LVL_MIN;
      n.eng.hold_cnt  = '0;
    end else begin
      case (r.eng.phase)
        BL_IDLE: begin
          n.eng.phase = BL_UP;
        end
        BL_UP: begin
          if (r.eng.blink_lvl == `LGC_LVL_MAX) begin
            n.eng.phase    = BL_ON;
            n.eng.hold_cnt = '0;
          end else if (m_up == 5'h00) begin
            n.eng.blink_lvl = `LGC_LVL_MAX;
          end else if (up_tick) begin
            n.eng.blink_lvl = r.eng.blink_lvl + 6'h01;
          end
        end
        BL_ON: begin
          if (r.eng.hold_cnt >= hold_len(r.cfg.hold_timer[`LGC_T_FAST])) begin
            n.eng.phase = BL_DOWN;
          end else if (base_tick) begin
            n.eng.hold_cnt = r.eng.hold_cnt + 11'h001;
          end
        end
        BL_DOWN: begin
          if (r.eng.blink_lvl == `LGC_LVL_MIN) begin
            n.eng.phase    = BL_OFF;
            n.eng.hold_cnt = '0;
          end else if (m_dn == 5'h00) begin
            n.eng.blink_lvl = `LGC_LVL_MIN;
          end else if (dn_tick) begin
            n.eng.blink_lvl = r.eng.blink_lvl - 6'h01;
          end
        end
        BL_OFF: begin
          if (r.eng.hold_cnt >= hold_len(r.cfg.hold_timer[`LGC_T_SLOW])) begin
            n.eng.phase = BL_UP;
          end else if (base_tick) begin
            n.eng.hold_cnt = r.eng.hold_cnt + 11'h001;
          end
        end
        default: begin
          n.eng.phase = BL_IDLE;
        end
      endcase
    end

    // latched fade follows the output bit toward full or dark
    for (int c = 0; c < 6; c++) begin
      if (fade_m[c]) begin
        if (r.cfg.out_lvl[c] && r.eng.fade_lvl[c] != `LGC_LVL_MAX) begin
          if (m_up == 5'h00) begin
            n.eng.fade_lvl[c] = `LGC_LVL_MAX;
          end else if (up_tick) begin
            n.eng.fade_lvl[c] = r.eng.fade_lvl[c] + 6'h01;
          end
        end else if (!r.cfg.out_lvl[c] && r.eng.fade_lvl[c] != `LGC_LVL_MIN) begin
          if (m_dn == 5'h00) begin
            n.eng.fade_lvl[c] = `LGC_LVL_MIN;
          end else if (dn_tick) begin
            n.eng.fade_lvl[c] = r.eng.fade_lvl[c] - 6'h01;
          end
        end
      end
    end

    // register writes keep only defined bits
    if (i_req.wr) begin
      case (i_req.addr)
        `LGC_A_OUT_HI:  n.cfg.out_lvl[`LGC_HI]    = i_req.wdata[`LGC_HI_FLD];
        `LGC_A_OUT_LO:  n.cfg.out_lvl[`LGC_LO]    = i_req.wdata[`LGC_LO_FLD];
        `LGC_A_DIR_HI:  n.cfg.dir[`LGC_HI]        = i_req.wdata[`LGC_HI_FLD];
        `LGC_A_DIR_LO:  n.cfg.dir[`LGC_LO]        = i_req.wdata[`LGC_LO_FLD];
        `LGC_A_BLK_HI:  n.cfg.irq_blk[`LGC_HI]    = i_req.wdata[`LGC_HI_FLD];
        `LGC_A_BLK_LO:  n.cfg.irq_blk[`LGC_LO]    = i_req.wdata[`LGC_LO_FLD];
        `LGC_A_KIND_HI: n.cfg.kind[`LGC_HI]       = i_req.wdata[`LGC_HI_FLD];
        `LGC_A_KIND_LO: n.cfg.kind[`LGC_LO]       = i_req.wdata[`LGC_LO_FLD];
        `LGC_A_BREATH:  n.cfg.breath_en           = i_req.wdata[`LGC_CH6_FLD];
        `LGC_A_RAMP:    n.cfg.ramp_timer          = i_req.wdata[`LGC_CH6_FLD];
        `LGC_A_HOLD:    n.cfg.hold_timer          = i_req.wdata[`LGC_CH6_FLD];
        `LGC_A_GCTL: begin
          n.cfg.go                   = i_req.wdata[`LGC_GC_GO];
          n.cfg.drive_style_select   = i_req.wdata[`LGC_GC_DRIVE];
          n.cfg.current_range_select = i_req.wdata[`LGC_GC_RANGE];
        end
        `LGC_A_SWRST: swrst = (i_req.wdata == `LGC_SWRST_CODE);
        default: begin
          // a channel in latched fade keeps its programmed code
          if (i_req.addr >= `LGC_A_BRIGHT0 && i_req.addr <= `LGC_A_BRIGHT5
              && !fade_m[bch]) begin
            n.cfg.bright[bch] = i_req.wdata;
          end
        end
      endcase
    end

    // Reads answer one cycle later; input reads clear their pending flags
    n.rsp.rvalid = i_req.rd;
    n.rsp.rdata  = `LGC_RST_BYTE;
    if (i_req.rd) begin
      case (i_req.addr)
        `LGC_A_IN_HI: begin
          n.rsp.rdata        = rd_hi(r.io.in_lvl);
          rd_clr[`LGC_HI]    = 2'h3;
        end
        `LGC_A_IN_LO: begin
          n.rsp.rdata        = rd_lo(r.io.in_lvl);
          rd_clr[`LGC_LO]    = 4'hf;
        end
        `LGC_A_OUT_HI:  n.rsp.rdata = rd_hi(r.cfg.out_lvl);
        `LGC_A_OUT_LO:  n.rsp.rdata = rd_lo(r.cfg.out_lvl);
        `LGC_A_DIR_HI:  n.rsp.rdata = rd_hi(r.cfg.dir);
        `LGC_A_DIR_LO:  n.rsp.rdata = rd_lo(r.cfg.dir);
        `LGC_A_BLK_HI:  n.rsp.rdata = rd_hi(r.cfg.irq_blk);
        `LGC_A_BLK_LO:  n.rsp.rdata = rd_lo(r.cfg.irq_blk);
        `LGC_A_KIND_HI: n.rsp.rdata = rd_hi(r.cfg.kind);
        `LGC_A_KIND_LO: n.rsp.rdata = rd_lo(r.cfg.kind);
        `LGC_A_BREATH:  n.rsp.rdata = {2'h0, r.cfg.breath_en};
        `LGC_A_RAMP:    n.rsp.rdata = {2'h0, r.cfg.ramp_timer};
        `LGC_A_HOLD:    n.rsp.rdata = {2'h0, r.cfg.hold_timer};
        `LGC_A_GCTL:    n.rsp.rdata = {r.cfg.go, 2'h0, r.cfg.drive_style_select,
                                       2'h0, r.cfg.current_range_select};
        `LGC_A_SWRST:   n.rsp.rdata = P_IDENT;
        default:        n.rsp.rdata = `LGC_RST_BYTE;
      endcase
    end
    // Set wins over the read clear
    n.io.pend = (r.io.pend & ~rd_clr) | evt;

    // software reset returns settings and engines, straps are re-read
    if (swrst) begin
      n.cfg           = CFG_RST;
      n.eng           = '0;
      n.io.pend       = '0;
      n.io.strap_cnt  = 2'h0;
      n.io.strap_done = 1'b0;
    end

    n.led.current_range_select = r.cfg.current_range_select;
    n.led.sink_en              = ~r.cfg.kind;
    for (int c = 0; c < 6; c++) begin
      if (r.cfg.kind[c]) begin
        n.led.brightness_code[c] = `LGC_RST_BYTE;
      end else if (blink_m[c]) begin
        n.led.brightness_code[c] = expand(r.eng.blink_lvl);
      end else if (fade_m[c]) begin
        n.led.brightness_code[c] = expand(r.eng.fade_lvl[c]);
      end else begin
        n.led.brightness_code[c] = r.cfg.bright[c];
      end
      // pin drive only for general outputs
      n.pin_o[c]  = 1'b0;
      n.pin_oe[c] = 1'b0;
      if (r.cfg.kind[c] && !r.cfg.dir[c]) begin
        if (c >= `LGC_OD_FIRST && !r.cfg.drive_style_select) begin
          n.pin_oe[c] = !r.cfg.out_lvl[c];
        end else begin
          n.pin_o[c]  = r.cfg.out_lvl[c];
          n.pin_oe[c] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  assign o_rsp           = r.rsp;
  assign o_led           = r.led;
  assign o_pin_out       = r.pin_o;
  assign o_pin_oe        = r.pin_oe;
  assign o_irq_out_low_n = ~|r.io.pend;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  property p_linear;
    !r.cfg.kind[0] && !r.cfg.breath_en[0] |=> o_led.brightness_code[0] == $past(r.cfg.bright[0]);
  endproperty
  a_linear: assert property (p_linear) else $error("code not passed");

  property p_blink_start;
    r.cfg.go && r.eng.phase == BL_IDLE |=> r.eng.phase == BL_UP;
  endproperty
  a_blink_start: assert property (p_blink_start) else $error("blink not started");

  property p_open_drain;
    r.cfg.kind[4] && !r.cfg.dir[4] && !r.cfg.drive_style_select
      |=> o_pin_oe[4] == !$past(r.cfg.out_lvl[4]) && !o_pin_out[4];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain wrong");

  property p_range;
    i_req.wr && i_req.addr == `LGC_A_GCTL
      |=> r.cfg.current_range_select == $past(i_req.wdata[`LGC_GC_RANGE])
      ##1 o_led.current_range_select == $past(r.cfg.current_range_select);
  endproperty
  a_range: assert property (p_range) else $error("range not taken");

  property p_gpio_out;
    r.cfg.kind[0] && !r.cfg.dir[0] |=> o_pin_oe[0] && o_pin_out[0] == $past(r.cfg.out_lvl[0]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("pin level wrong");

  property p_step_rate;
    base_tick && m_up == 5'h01 |-> up_tick;
  endproperty
  a_step_rate: assert property (p_step_rate) else $error("315 ms rate off");

  property p_fade_up;
    fade_m[0] && r.cfg.out_lvl[0] && r.eng.fade_lvl[0] != `LGC_LVL_MAX && up_tick
      |=> r.eng.fade_lvl[0] == $past(r.eng.fade_lvl[0]) + 6'h01;
  endproperty
  a_fade_up: assert property (p_fade_up) else $error("fade up stalled");

  property p_fade_freeze;
    i_req.wr && i_req.addr == `LGC_A_BRIGHT0 && fade_m[0]
      |=> $stable(r.cfg.bright[0]);
  endproperty
  a_fade_freeze: assert property (p_fade_freeze) else $error("code written in fade");

  property p_ident;
    i_req.rd && i_req.addr == `LGC_A_SWRST |=> o_rsp.rvalid && o_rsp.rdata == P_IDENT;
  endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");

  property p_swrst;
    i_req.wr && i_req.addr == `LGC_A_SWRST && i_req.wdata == `LGC_SWRST_CODE
      |=> r.cfg.kind == `LGC_RST_KIND && r.cfg.breath_en == `LGC_RST_ZERO6 && !r.io.strap_done;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset missed");

  property p_irq;
    |evt |=> !o_irq_out_low_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_reserved;
    i_req.rd && i_req.addr == `LGC_A_RAMP
      |=> o_rsp.rdata == {2'h0, $past(r.cfg.ramp_timer)};
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_strap;
    strap_load |=> r.cfg.out_lvl == {6{|$past(r.io.st3)}};
  endproperty
  a_strap: assert property (p_strap) else $error("strap level lost");

  sequence s_top;
    r.cfg.go && r.eng.phase == BL_UP && r.eng.blink_lvl == `LGC_LVL_MAX;
  endsequence
  sequence s_lit;
    r.eng.phase == BL_ON;
  endsequence
  property p_blink_order;
    s_top ##1 r.cfg.go |-> s_lit;
  endproperty
  a_blink_order: assert property (p_blink_order) else $error("blink skipped hold");

endmodule

// ==== testbench/lgc_host.sv ====
// Purpose: host model driving the byte register port
// Assumes: slave address already matched upstream
// Notes:   idle address and data lines show the inverse of the last value
module lgc_host
  import lgc_pkg::*;
(
  // Clock
  input  wire logic     i_clk_sys,
  // Register port
  output lgc_req_t      o_req,
  input  wire lgc_rsp_t i_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [8:0] r);
    @(posedge i_clk_sys);
    #1 o_req = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge i_clk_sys);
    #1 r = {i_rsp.rvalid, i_rsp.rdata};
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// ==== testbench/lgc_regs_bench.sv ====
// Purpose: self-checking bench for the channel register bank
// Assumes: short fade step so blink runs in a few hundred cycles
// Notes:   register model keyed by offset; pin level resolved here
module lgc_regs_bench
  import lgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 4;
  // Arbitrary identity value
  localparam logic [7:0] ID = 8'h3c;
  logic            clk = 1'b0;
  logic            arst_n = 1'b0;
  logic [5:0]      ext = 6'h00;
  logic            sl = 1'b1;
  logic            sh = 1'b0;
  lgc_req_t        req;
  lgc_rsp_t        rsp;
  lgc_led_t        led;
  logic [5:0]      p_o;
  logic [5:0]      p_oe;
  logic [5:0]      pin;
  logic            irq_n;
  logic [31:0]     seed = 32'h8909a6d1;
  logic [7:0]      mdl [256];
  logic [7:0]      lst [12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
  int              fail_count = 0;
  int              checks = 0;
  always #5 clk = ~clk;
  // Driven pins win over the outside level
  assign pin = (p_oe & p_o) | (~p_oe & ext);
  lgc_regs #(.P_STEP_CYCLES(STEP), .P_IDENT(ID)) uut (.i_clk_sys(clk), .i_arst_n(arst_n),
    .i_req(req), .o_rsp(rsp), .i_pin_in(pin), .o_pin_out(p_o), .o_pin_oe(p_oe),
    .i_address_strap_low(sl), .i_address_strap_high(sh), .o_led(led), .o_irq_out_low_n(irq_n));
  lgc_host host (.i_clk_sys(clk), .o_req(req), .i_rsp(rsp));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h02, 8'h04, 8'h06, 8'h12: return 8'h03;
      8'h03, 8'h05, 8'h07, 8'h13: return 8'h0f;
      8'h11: return 8'h93;
      8'h14, 8'h15, 8'h16: return 8'h3f;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [15:0] exp_pin(input logic [5:0] v, input logic s);
    logic [15:0] e;
    e = '0;
    for (int c = 0; c < 6; c++) begin
      e[c+6] = (c < 4 || s) & v[c];
      e[c] = (c < 4 || s) | ~v[c];
    end
    return e;
  endfunction
  task automatic cmp(input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_rd(input logic [8:0] g, e); cmp({7'h0, g}, {7'h0, e}); endtask
  task automatic chk_pin(input logic [15:0] g, e); cmp(g, e); endtask
  task automatic cyc(input int n); repeat (n) @(posedge clk); #1; endtask
  task automatic wr(input logic [7:0] a, d);
    logic [8:0] r;
    host.xfer(1'b1, a, d, r);
    if (msk(a) !== 8'h00) mdl[a] = d & msk(a);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [8:0] r;
    host.xfer(1'b0, a, 8'h00, r);
    chk_rd(r, {1'b1, (a == 8'h7f) ? ID : mdl[a]});
  endtask
  task automatic mreset();
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h12] = 8'h03;
    mdl[8'h13] = 8'h0f;
    mdl[8'h02] = (sl | sh) ? 8'h03 : 8'h00;
    mdl[8'h03] = (sl | sh) ? 8'h0f : 8'h00;
  endtask
  task automatic check_all();
    foreach (lst[i]) rd(lst[i]);
    rd(8'h7f);
    rd(8'h30);
    rd(8'h20);
  endtask
  task automatic wait_code(input int c, input logic [7:0] e, input int mx, output int n);
    n = 0;
    while (led.brightness_code[c] !== e && n < mx) begin
      cyc(1);
      n++;
    end
    chk_pin({8'h0, led.brightness_code[c]}, {8'h0, e});
  endtask
  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    logic [31:0] r;
    logic [5:0]  old;
    logic [7:0]  b;
    logic [7:0]  b0;
    int          n;
    mreset();
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    cyc(10);
    check_all();
    foreach (lst[i]) wr(lst[i], 8'(rnd()));
    check_all();
    wr(8'h7f, 8'h01);
    check_all();
    sl = 1'b0;
    wr(8'h7f, 8'h00);
    mreset();
    cyc(10);
    check_all();
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      wr(8'h11, {3'b0, r[8], 4'b0});
      wr(8'h02, {6'b0, r[5:4]});
      wr(8'h03, {4'b0, r[3:0]});
      cyc(2);
      chk_pin({4'h0, p_o, p_oe}, exp_pin(r[5:0], r[8]));
    end
    wr(8'h04, 8'h03);
    wr(8'h05, 8'h0f);
    cyc(8);
    rd(8'h30);
    for (int i = 0; i < 5; i++) begin
      mdl[8'h00] = {2'b0, ext[5:4]};
      mdl[8'h01] = {4'b0, ext[3:0]};
      rd(8'h00);
      rd(8'h01);
      cyc(1);
      chk_pin({15'h0, irq_n}, 16'h1);
      r = rnd();
      wr(8'h06, {6'b0, r[13:12]});
      wr(8'h07, {4'b0, r[11:8]});
      old = ext;
      ext = r[5:0];
      cyc(8);
      chk_pin({15'h0, irq_n}, {15'h0, ~|((ext ^ old) & ~r[13:8])});
    end
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h00);
    r = rnd();
    wr(8'h11, {6'b0, r[1:0]});
    for (int c = 0; c < 6; c++) begin
      b = 8'(rnd());
      if (c == 0) b0 = b;
      wr(8'(8'h20 + c), b);
      cyc(2);
      chk_pin({led.sink_en, led.current_range_select, led.brightness_code[c]},
              {6'h3f, r[1:0], b});
    end
    wr(8'h05, 8'h02);
    wr(8'h03, 8'h00);
    wr(8'h14, 8'h03);
    wait_code(0, 8'h00, 8, n);
    wr(8'h20, 8'hff);
    cyc(4);
    chk_pin({8'h0, led.brightness_code[0]}, 16'h0000);
    wr(8'h03, 8'h01);
    wait_code(0, 8'hff, 8, n);
    // Reverse only after the fade has finished
    wr(8'h03, 8'h00);
    wait_code(0, 8'h00, 8, n);
    wr(8'h15, 8'h09);
    wr(8'h16, 8'h09);
    wr(8'h11, 8'h80);
    wait_code(1, 8'hff, 600, n);
    chk_pin({15'h0, n inside {[248:264]}}, 16'h1);
    wait_code(1, 8'h00, 1200, n);
    chk_pin({15'h0, n inside {[480:540]}}, 16'h1);
    wait_code(1, 8'hff, 1200, n);
    wr(8'h11, 8'h00);
    wait_code(1, 8'h00, 4, n);
    wr(8'h14, 8'h00);
    cyc(2);
    chk_pin({8'h0, led.brightness_code[0]}, {8'h0, b0});
    wrap_up();
  end
endmodule
